//--- pmca_array.sv
`timescale 1ns/100ps
module pmca_array (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        global_clock_pin_a_i,
	input  wire logic        global_clear_pin_low_i,
	input  wire logic        output_enable_pin_a_low_i,
	input  wire logic        output_enable_pin_b_low_i,
	input  wire logic [15:0] io_pin_i,
	output logic      [15:0] io_pin_o,
	output logic      [15:0] io_pin_oe_o
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [3:0]  ded_meta_reg;
	logic [3:0]  ded_sync_reg;
	logic [15:0] io_meta_reg;
	logic [15:0] io_sync_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ded_meta_reg <= 4'hF;
			ded_sync_reg <= 4'hF;
			io_meta_reg  <= 16'h0000;
			io_sync_reg  <= 16'h0000;
		end else begin
			ded_meta_reg <= {output_enable_pin_b_low_i, output_enable_pin_a_low_i,
				global_clear_pin_low_i, global_clock_pin_a_i};
			ded_sync_reg <= ded_meta_reg;
			io_meta_reg  <= io_pin_i;
			io_sync_reg  <= io_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers and APB slave
	// ----------------------------------------------------------------
	logic [31:0] global_cfg_reg;
	logic [35:0] route_en_reg;
	logic [31:0] mc_cfg_reg [pmca_pkg::N_MC];
	logic [31:0] io_cfg_reg [pmca_pkg::N_MC];
	logic [31:0] oe_cfg_reg [pmca_pkg::N_GOE];
	logic [31:0] pt_word_reg [pmca_pkg::N_PT_WORD];
	logic [31:0] rd_data;
	logic        rd_hit;
	logic        wr_en;
	logic        pready_next;
	logic [11:0] pt_off;
	logic [8:0]  pt_idx;
	logic [2:0]  oe_idx;
	logic [15:0] mc_out_reg;
	logic        enh;
	logic        isp;

	assign enh         = global_cfg_reg[pmca_pkg::GC_ENH];
	assign isp         = global_cfg_reg[pmca_pkg::GC_ISP];
	assign pt_off      = paddr_i - pmca_pkg::PT_BASE;
	assign pt_idx      = pt_off[10:2];
	assign oe_idx      = paddr_i[4:2];
	// Answer one cycle into the access phase
	assign pready_next = psel_i & penable_i & ~pready_o;
	assign wr_en       = psel_i & penable_i & pwrite_i & pready_o;

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (paddr_i[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else if (paddr_i == pmca_pkg::GLOBAL_CFG_OFF) begin
			rd_data = global_cfg_reg;
		end else if (paddr_i == pmca_pkg::ROUTE_EN_LO_OFF) begin
			rd_data = route_en_reg[31:0];
		end else if (paddr_i == pmca_pkg::ROUTE_EN_HI_OFF) begin
			rd_data = {28'h000_0000, route_en_reg[35:32]};
		end else if (paddr_i == pmca_pkg::MC_STATE_OFF) begin
			rd_data = {16'h0000, mc_out_reg};
		end else if (paddr_i == pmca_pkg::PIN_STATE_OFF) begin
			rd_data = {16'h0000, io_sync_reg};
		end else if (paddr_i >= pmca_pkg::MC_CFG_BASE && paddr_i < pmca_pkg::IO_CFG_BASE) begin
			rd_data = mc_cfg_reg[paddr_i[5:2]];
		end else if (paddr_i >= pmca_pkg::IO_CFG_BASE && paddr_i < pmca_pkg::OE_CFG_BASE) begin
			rd_data = io_cfg_reg[paddr_i[5:2]];
		end else if (paddr_i >= pmca_pkg::OE_CFG_BASE && paddr_i < pmca_pkg::OE_CFG_END) begin
			rd_data = oe_cfg_reg[oe_idx];
		end else if (paddr_i >= pmca_pkg::PT_BASE && paddr_i < pmca_pkg::PT_END) begin
			rd_data = pt_word_reg[pt_idx];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= pready_next;
			pslverr_o <= pready_next & ~rd_hit;
			prdata_o  <= (pready_next & ~pwrite_i) ? rd_data : 32'h0000_0000;
		end
	end

	// Loaded only by software; meant to be set up before user operation
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			global_cfg_reg <= pmca_pkg::CFG_RESET;
			route_en_reg   <= 36'h0_0000_0000;
			for (int i = 0; i < pmca_pkg::N_MC; i++) begin
				mc_cfg_reg[i] <= pmca_pkg::CFG_RESET;
				io_cfg_reg[i] <= pmca_pkg::CFG_RESET;
			end
			for (int i = 0; i < pmca_pkg::N_GOE; i++) begin
				oe_cfg_reg[i] <= pmca_pkg::CFG_RESET;
			end
			for (int i = 0; i < pmca_pkg::N_PT_WORD; i++) begin
				pt_word_reg[i] <= pmca_pkg::CFG_RESET;
			end
		end else if (wr_en && rd_hit) begin
			if (paddr_i == pmca_pkg::GLOBAL_CFG_OFF) begin
				global_cfg_reg <= pwdata_i;
			end else if (paddr_i == pmca_pkg::ROUTE_EN_LO_OFF) begin
				route_en_reg[31:0] <= pwdata_i;
			end else if (paddr_i == pmca_pkg::ROUTE_EN_HI_OFF) begin
				route_en_reg[35:32] <= pwdata_i[3:0];
			end else if (paddr_i >= pmca_pkg::MC_CFG_BASE && paddr_i < pmca_pkg::IO_CFG_BASE) begin
				mc_cfg_reg[paddr_i[5:2]] <= pwdata_i;
			end else if (paddr_i >= pmca_pkg::IO_CFG_BASE && paddr_i < pmca_pkg::OE_CFG_BASE) begin
				io_cfg_reg[paddr_i[5:2]] <= pwdata_i;
			end else if (paddr_i >= pmca_pkg::OE_CFG_BASE && paddr_i < pmca_pkg::OE_CFG_END) begin
				oe_cfg_reg[oe_idx] <= pwdata_i;
			end else if (paddr_i >= pmca_pkg::PT_BASE && paddr_i < pmca_pkg::PT_END) begin
				pt_word_reg[pt_idx] <= pwdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Global controls and routing
	// ----------------------------------------------------------------
	logic [1:0]  gclk;
	logic [1:0]  gclk_prev_reg;
	logic [1:0]  gclk_rise;
	logic        gclr_active;
	logic [5:0]  goe;
	logic [35:0] route_src;
	logic [35:0] route_in;
	logic [15:0] share_reg;
	logic [51:0] lits;
	logic        global_clock_pin_b;
	logic        pin_a_clk;
	logic        pin_b_clk;

	assign global_clock_pin_b = ded_sync_reg[3];
	assign pin_a_clk = ded_sync_reg[0] & global_cfg_reg[pmca_pkg::GC_CLKA_EN];
	assign pin_b_clk = global_clock_pin_b & global_cfg_reg[pmca_pkg::GC_CLKB_EN];
	assign gclr_active = global_cfg_reg[pmca_pkg::GC_CLR_EN] & ~ded_sync_reg[1];

	always_comb begin
		if (enh) begin
			gclk[0] = (global_cfg_reg[pmca_pkg::GC_G0_SRC] ? pin_b_clk : pin_a_clk)
				^ global_cfg_reg[pmca_pkg::GC_G0_INV];
			gclk[1] = (global_cfg_reg[pmca_pkg::GC_G1_SRC] ? pin_b_clk : pin_a_clk)
				^ global_cfg_reg[pmca_pkg::GC_G1_INV];
		end else begin
			gclk[0] = pin_a_clk;
			gclk[1] = 1'b0;
		end
	end
	assign gclk_rise = gclk & ~gclk_prev_reg;

	always_comb begin
		logic       sig;
		logic [3:0] idx;
		sig = 1'b0;
		idx = 4'h0;
		goe = 6'h00;
		if (!enh) begin
			goe[0] = global_cfg_reg[pmca_pkg::GC_OEA_EN] & ~ded_sync_reg[2];
			goe[1] = global_cfg_reg[pmca_pkg::GC_OEB_EN] & ~ded_sync_reg[3];
		end else begin
			for (int k = 0; k < pmca_pkg::N_GOE; k++) begin
				idx = oe_cfg_reg[k][pmca_pkg::OE_IDX_LSB +: 4];
				unique case (oe_cfg_reg[k][pmca_pkg::OE_KIND_LSB +: 2])
					pmca_pkg::OE_KIND_SIG: sig = idx[0] ? ~ded_sync_reg[3] : ~ded_sync_reg[2];
					pmca_pkg::OE_KIND_PIN: sig = io_sync_reg[idx];
					pmca_pkg::OE_KIND_MC:  sig = mc_out_reg[idx];
					default:               sig = 1'b0;
				endcase
				goe[k] = sig ^ oe_cfg_reg[k][pmca_pkg::OE_INV];
			end
		end
	end

	// Pin and macrocell feedback are separate sources
	assign route_src = {mc_out_reg, io_sync_reg, ded_sync_reg};
	assign route_in  = route_src & route_en_reg;
	assign lits      = {share_reg, route_in};

	// ----------------------------------------------------------------
	// Product terms
	// ----------------------------------------------------------------
	// A term with no literal selected is unprogrammed and reads low
	function automatic logic pmca_term(input logic [103:0] mask, input logic [51:0] in);
		logic hit;
		hit = |mask;
		for (int i = 0; i < pmca_pkg::N_LIT; i++) begin
			if (mask[i] && !in[i]) hit = 1'b0;
			if (mask[pmca_pkg::N_LIT + i] && in[i]) hit = 1'b0;
		end
		return hit;
	endfunction : pmca_term

	logic [79:0] pt_val;

	always_comb begin
		for (int t = 0; t < pmca_pkg::N_PT_ALL; t++) begin
			pt_val[t] = pmca_term({pt_word_reg[t * 4 + 3][7:0], pt_word_reg[t * 4 + 2],
				pt_word_reg[t * 4 + 1], pt_word_reg[t * 4]}, lits);
		end
	end

	// ----------------------------------------------------------------
	// Macrocells
	// ----------------------------------------------------------------
	logic [15:0] or_sum;
	logic [15:0] kr_sum;
	logic [15:0] clr_pt;
	logic [15:0] pre_pt;
	logic [15:0] aclk;
	logic [15:0] cen;
	logic [15:0] lend_sum;
	logic [15:0] borrow_sum;
	logic [15:0] logic_out;
	logic [15:0] tick;
	logic [15:0] ff_reg;
	logic [15:0] ff_next;
	logic [15:0] mc_out_next;
	logic [15:0] aclk_prev_reg;
	logic [15:0] share_next;

	always_comb begin
		logic [2:0] role;
		logic       has_cen;
		role = 3'h0;
		has_cen = 1'b0;
		for (int m = 0; m < pmca_pkg::N_MC; m++) begin
			or_sum[m] = 1'b0;
			kr_sum[m] = 1'b0;
			clr_pt[m] = 1'b0;
			pre_pt[m] = 1'b0;
			aclk[m] = 1'b0;
			cen[m] = 1'b0;
			lend_sum[m] = 1'b0;
			has_cen = 1'b0;
			for (int p = 0; p < pmca_pkg::N_PT; p++) begin
				role = mc_cfg_reg[m][3 * p +: 3];
				if (role == pmca_pkg::ROLE_OR) or_sum[m] |= pt_val[m * 5 + p];
				if (role == pmca_pkg::ROLE_KR) kr_sum[m] |= pt_val[m * 5 + p];
				if (role == pmca_pkg::ROLE_CLR) clr_pt[m] |= pt_val[m * 5 + p];
				if (role == pmca_pkg::ROLE_PRE) pre_pt[m] |= pt_val[m * 5 + p];
				if (role == pmca_pkg::ROLE_CLK) aclk[m] |= pt_val[m * 5 + p];
				if (role == pmca_pkg::ROLE_CEN) begin
					cen[m] |= pt_val[m * 5 + p];
					has_cen = 1'b1;
				end
				// Chain top never lends
				if (role == pmca_pkg::ROLE_LEND && (m % pmca_pkg::CHAIN_LEN) != 7) begin
					lend_sum[m] |= pt_val[m * 5 + p];
				end
			end
			// Without an enable term the register clocks on every edge
			if (!has_cen) cen[m] = 1'b1;
		end
	end

	always_comb begin
		for (int m = 0; m < pmca_pkg::N_MC; m++) begin
			borrow_sum[m] = 1'b0;
			// Sets come from consecutive lower cells of the same chain only
			for (int k = 1; k <= pmca_pkg::MAX_SETS; k++) begin
				if (k <= int'(mc_cfg_reg[m][pmca_pkg::MC_BORROW_LSB +: 2])
					&& k <= (m % pmca_pkg::CHAIN_LEN)) begin
					borrow_sum[m] |= lend_sum[m - k];
				end
			end
			logic_out[m] = (or_sum[m] | borrow_sum[m]) ^ mc_cfg_reg[m][pmca_pkg::MC_XOR_INV];
		end
	end

	always_comb begin
		logic d;
		logic [2:0] s;
		d = 1'b0;
		s = 3'h0;
		for (int m = 0; m < pmca_pkg::N_MC; m++) begin
			s = mc_cfg_reg[m][pmca_pkg::MC_SHARE_LSB +: 3];
			share_next[m] = (s < 3'h5) ? ~pt_val[m * 5 + int'(s)] : 1'b0;
			unique case (mc_cfg_reg[m][pmca_pkg::MC_CLK_LSB +: 2])
				pmca_pkg::CLK_GLOBAL: tick[m] = gclk_rise[mc_cfg_reg[m][pmca_pkg::MC_GCLK_SEL]];
				pmca_pkg::CLK_GLB_EN: tick[m] = gclk_rise[mc_cfg_reg[m][pmca_pkg::MC_GCLK_SEL]]
					& cen[m];
				pmca_pkg::CLK_ARRAY:  tick[m] = aclk[m] & ~aclk_prev_reg[m];
				default:              tick[m] = 1'b0;
			endcase
			d = (enh && mc_cfg_reg[m][pmca_pkg::MC_FAST_IN]) ? io_sync_reg[m] : logic_out[m];
			ff_next[m] = ff_reg[m];
			if (tick[m]) begin
				unique case (mc_cfg_reg[m][pmca_pkg::MC_FF_LSB +: 2])
					pmca_pkg::FF_D:  ff_next[m] = d;
					pmca_pkg::FF_T:  ff_next[m] = ff_reg[m] ^ logic_out[m];
					pmca_pkg::FF_JK: ff_next[m] = (logic_out[m] & ~ff_reg[m])
						| (~kr_sum[m] & ff_reg[m]);
					pmca_pkg::FF_SR: ff_next[m] = logic_out[m] ? 1'b1
						: (kr_sum[m] ? 1'b0 : ff_reg[m]);
				endcase
			end
			// Clear outranks preset
			if (clr_pt[m] || (gclr_active && mc_cfg_reg[m][pmca_pkg::MC_GCLR_EN])) begin
				ff_next[m] = 1'b0;
			end else if (pre_pt[m]) begin
				ff_next[m] = 1'b1;
			end
			mc_out_next[m] = mc_cfg_reg[m][pmca_pkg::MC_BYPASS] ? logic_out[m] : ff_next[m];
		end
	end

	// Feedback is registered to keep the array free of combinational loops
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ff_reg        <= 16'h0000;
			mc_out_reg    <= 16'h0000;
			share_reg     <= 16'h0000;
			gclk_prev_reg <= 2'h0;
			aclk_prev_reg <= 16'h0000;
		end else begin
			ff_reg        <= ff_next;
			mc_out_reg    <= mc_out_next;
			share_reg     <= share_next;
			gclk_prev_reg <= gclk;
			aclk_prev_reg <= aclk;
		end
	end

	// ----------------------------------------------------------------
	// I/O control
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			io_pin_o    <= 16'h0000;
			io_pin_oe_o <= 16'h0000;
		end else begin
			for (int p = 0; p < pmca_pkg::N_MC; p++) begin
				logic [2:0] sel;
				logic       en;
				sel = io_cfg_reg[p][pmca_pkg::IO_OE_LSB +: 3];
				if (sel == pmca_pkg::OE_SEL_LOW) en = 1'b0;
				else if (sel == pmca_pkg::OE_SEL_HI) en = 1'b1;
				else en = goe[sel - pmca_pkg::OE_SEL_G0];
				if (isp && io_cfg_reg[p][pmca_pkg::IO_OD]) begin
					io_pin_o[p]    <= 1'b0;
					io_pin_oe_o[p] <= en & ~mc_out_reg[p];
				end else begin
					io_pin_o[p]    <= mc_out_reg[p];
					io_pin_oe_o[p] <= en;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence apb_wait_s;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence apb_done_s;
		pready_o ##1 !pready_o;
	endsequence

	apb_answer_a: assert property (@(posedge clk_i) disable iff (reset_i)
		apb_wait_s |=> apb_done_s)
		else $error("apb access not answered in one cycle");

	power_up_zero_a: assert property (@(posedge clk_i)
		reset_i |=> (ff_reg == 16'h0000 && mc_out_reg == 16'h0000))
		else $error("macrocell registers not zero after reset");

	chain_ends_a: assert property (@(posedge clk_i) disable iff (reset_i)
		borrow_sum[0] == 1'b0 && borrow_sum[8] == 1'b0
		&& lend_sum[7] == 1'b0 && lend_sum[15] == 1'b0)
		else $error("chain end lends or borrows");

	global_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(gclr_active && mc_cfg_reg[0][pmca_pkg::MC_GCLR_EN]) |=> ff_reg[0] == 1'b0)
		else $error("global clear did not clear register");

	term_preset_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(pre_pt[0] && !clr_pt[0] && !gclr_active) |=> ff_reg[0] == 1'b1)
		else $error("preset term did not set register");

	basic_clock_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!enh |-> (gclk[1] == 1'b0 && gclk[0] == (ded_sync_reg[0]
		& global_cfg_reg[pmca_pkg::GC_CLKA_EN])))
		else $error("basic clocking wrong");

	basic_enables_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!enh |-> (goe[5:2] == 4'h0 && (goe[0] -> !ded_sync_reg[2])))
		else $error("basic output enables wrong");

	input_only_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(io_cfg_reg[0][2:0] == pmca_pkg::OE_SEL_LOW) |=> !io_pin_oe_o[0])
		else $error("input-only pin driven");

	push_pull_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(!isp && io_cfg_reg[0][2:0] == pmca_pkg::OE_SEL_HI)
		|=> (io_pin_oe_o[0] && io_pin_o[0] == $past(mc_out_reg[0])))
		else $error("pin not driven from macrocell");

	bypass_path_a: assert property (@(posedge clk_i) disable iff (reset_i)
		mc_cfg_reg[0][pmca_pkg::MC_BYPASS] |=> mc_out_reg[0] == $past(logic_out[0]))
		else $error("bypassed macrocell not combinational");

	dff_capture_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(tick[1] && mc_cfg_reg[1][17:16] == pmca_pkg::FF_D && !mc_cfg_reg[1][23]
		&& !clr_pt[1] && !pre_pt[1] && !gclr_active) |=> ff_reg[1] == $past(logic_out[1]))
		else $error("D register missed clock tick");

endmodule : pmca_array

//--- pmca_pkg.sv
package pmca_pkg;

	// ----------------------------------------------------------------
	// Array dimensions
	// ----------------------------------------------------------------
	localparam int N_MC      = 16;
	localparam int N_PT      = 5;
	localparam int N_DED     = 4;
	localparam int N_ROUTE   = 36;
	localparam int N_LIT     = 52;
	localparam int MASK_W    = 104;
	localparam int N_GOE     = 6;
	localparam int CHAIN_LEN = 8;
	localparam int MAX_SETS  = 3;
	localparam int N_PT_ALL  = 80;
	localparam int PT_WORDS  = 4;
	localparam int N_PT_WORD = 320;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] GLOBAL_CFG_OFF  = 12'h000;
	localparam logic [11:0] ROUTE_EN_LO_OFF = 12'h004;
	localparam logic [11:0] ROUTE_EN_HI_OFF = 12'h008;
	localparam logic [11:0] MC_STATE_OFF    = 12'h010;
	localparam logic [11:0] PIN_STATE_OFF   = 12'h014;
	localparam logic [11:0] MC_CFG_BASE     = 12'h040;
	localparam logic [11:0] IO_CFG_BASE     = 12'h080;
	localparam logic [11:0] OE_CFG_BASE     = 12'h0C0;
	localparam logic [11:0] OE_CFG_END      = 12'h0D8;
	localparam logic [11:0] PT_BASE         = 12'h400;
	localparam logic [11:0] PT_END          = 12'h900;
	localparam logic [31:0] CFG_RESET       = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Global configuration fields
	// ----------------------------------------------------------------
	localparam int GC_ENH     = 0;
	localparam int GC_ISP     = 1;
	localparam int GC_CLKA_EN = 2;
	localparam int GC_CLR_EN  = 3;
	localparam int GC_OEA_EN  = 4;
	localparam int GC_OEB_EN  = 5;
	localparam int GC_CLKB_EN = 6;
	localparam int GC_G0_SRC  = 8;
	localparam int GC_G0_INV  = 9;
	localparam int GC_G1_SRC  = 10;
	localparam int GC_G1_INV  = 11;

	// ----------------------------------------------------------------
	// Macrocell configuration fields
	// ----------------------------------------------------------------
	localparam int MC_XOR_INV    = 15;
	localparam int MC_FF_LSB     = 16;
	localparam int MC_BYPASS     = 18;
	localparam int MC_CLK_LSB    = 19;
	localparam int MC_GCLK_SEL   = 21;
	localparam int MC_GCLR_EN    = 22;
	localparam int MC_FAST_IN    = 23;
	localparam int MC_BORROW_LSB = 24;
	localparam int MC_SHARE_LSB  = 26;

	localparam logic [2:0] ROLE_OR   = 3'h0;
	localparam logic [2:0] ROLE_CLR  = 3'h1;
	localparam logic [2:0] ROLE_PRE  = 3'h2;
	localparam logic [2:0] ROLE_CLK  = 3'h3;
	localparam logic [2:0] ROLE_CEN  = 3'h4;
	localparam logic [2:0] ROLE_LEND = 3'h5;
	localparam logic [2:0] ROLE_KR   = 3'h6;

	localparam logic [1:0] FF_D  = 2'h0;
	localparam logic [1:0] FF_T  = 2'h1;
	localparam logic [1:0] FF_JK = 2'h2;
	localparam logic [1:0] FF_SR = 2'h3;

	localparam logic [1:0] CLK_GLOBAL = 2'h0;
	localparam logic [1:0] CLK_GLB_EN = 2'h1;
	localparam logic [1:0] CLK_ARRAY  = 2'h2;

	// ----------------------------------------------------------------
	// Pin and output enable configuration fields
	// ----------------------------------------------------------------
	localparam int         IO_OE_LSB  = 0;
	localparam int         IO_OD      = 3;
	localparam logic [2:0] OE_SEL_LOW = 3'h0;
	localparam logic [2:0] OE_SEL_HI  = 3'h1;
	localparam logic [2:0] OE_SEL_G0  = 3'h2;

	localparam int         OE_KIND_LSB = 0;
	localparam int         OE_INV      = 2;
	localparam int         OE_IDX_LSB  = 3;
	localparam logic [1:0] OE_KIND_SIG = 2'h0;
	localparam logic [1:0] OE_KIND_PIN = 2'h1;
	localparam logic [1:0] OE_KIND_MC  = 2'h2;

endpackage : pmca_pkg

//--- pmca_board.sv
`timescale 1ns/100ps
module pmca_board (
	input  wire logic [15:0] dev_out_i,
	input  wire logic [15:0] dev_oe_i,
	input  wire logic [15:0] drive_i,
	output logic      [15:0] pin_level_o
);
	// Board sees the device level on driven pins, its own elsewhere
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_level_o[i] = dev_oe_i[i] ? dev_out_i[i] : drive_i[i];
		end
	end
endmodule : pmca_board

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk      = 1'b0;
	logic        reset    = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [11:0] paddr    = 12'h000;
	logic [31:0] pwdata   = 32'h0000_0000;
	logic        clk_a    = 1'b0;
	logic        clr_low  = 1'b1;
	logic        oe_a_low = 1'b1;
	logic        oe_b_low = 1'b1;
	logic [15:0] drive    = 16'h0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] pin_in;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic [31:0] q;
	logic        e;
	logic [31:0] r;
	int          failures    = 0;
	int          check_count = 0;

	always #5 clk = ~clk;

	pmca_array i_dut (.clk_i(clk), .reset_i(reset), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .global_clock_pin_a_i(clk_a),
		.global_clear_pin_low_i(clr_low), .output_enable_pin_a_low_i(oe_a_low),
		.output_enable_pin_b_low_i(oe_b_low), .io_pin_i(pin_in), .io_pin_o(pin_out),
		.io_pin_oe_o(pin_oe));

	pmca_board i_board (.dev_out_i(pin_out), .dev_oe_i(pin_oe), .drive_i(drive),
		.pin_level_o(pin_in));

	task automatic finish_test();
		if (failures == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// ----------------------------------------------------------------
	// APB master
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) failures++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask : rd

	task automatic pin_chk(input int p, input logic oe, input logic v);
		repeat (8) @(posedge clk);
		chk({30'h0, pin_oe[p], pin_out[p]}, {30'h0, oe, v});
	endtask : pin_chk

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h6359));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd(pmca_pkg::GLOBAL_CFG_OFF, pmca_pkg::CFG_RESET, 1'b0);
		rd(pmca_pkg::MC_STATE_OFF, 32'h0000_0000, 1'b0);
		chk({16'h0000, pin_oe}, 32'h0000_0000);
		rd(12'h00C, 32'h0000_0000, 1'b1);
		apb(1'b1, pmca_pkg::MC_STATE_OFF, 32'hFFFF_FFFF);
		rd(pmca_pkg::MC_STATE_OFF, 32'h0000_0000, 1'b0);
		r = $urandom;
		apb(1'b1, pmca_pkg::ROUTE_EN_LO_OFF, r);
		rd(pmca_pkg::ROUTE_EN_LO_OFF, r, 1'b0);
		// Macrocell 0 follows pin 5 through term 0; macrocell 1 is constant one
		apb(1'b1, pmca_pkg::ROUTE_EN_LO_OFF, 32'h0000_0200);
		apb(1'b1, pmca_pkg::PT_BASE, 32'h0000_0200);
		apb(1'b1, pmca_pkg::MC_CFG_BASE, 32'h0004_0000);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h004, 32'h0004_8000);
		apb(1'b1, pmca_pkg::IO_CFG_BASE, 32'h0000_0001);
		apb(1'b1, pmca_pkg::IO_CFG_BASE + 12'h004, 32'h0000_0002);
		apb(1'b1, pmca_pkg::GLOBAL_CFG_OFF, 32'h0000_001C);
		for (int i = 0; i < 8; i++) begin
			drive[5] <= 1'($urandom);
			repeat (2) @(posedge clk);
			pin_chk(0, 1'b1, drive[5]);
		end
		apb(1'b1, pmca_pkg::ROUTE_EN_LO_OFF, 32'h0000_0000);
		drive[5] <= 1'b1;
		pin_chk(0, 1'b1, 1'b0);
		apb(1'b1, pmca_pkg::ROUTE_EN_LO_OFF, 32'h0000_0200);
		pin_chk(1, 1'b0, 1'b1);
		oe_a_low <= 1'b0;
		pin_chk(1, 1'b1, 1'b1);
		oe_a_low <= 1'b1;
		pin_chk(1, 1'b0, 1'b1);
		// Registered D with global clock, following the global clear
		apb(1'b1, pmca_pkg::MC_CFG_BASE, 32'h0040_0000);
		pin_chk(0, 1'b1, 1'b0);
		clk_a <= 1'b1;
		pin_chk(0, 1'b1, 1'b1);
		drive[5] <= 1'b0;
		clk_a    <= 1'b0;
		pin_chk(0, 1'b1, 1'b1);
		clr_low <= 1'b0;
		pin_chk(0, 1'b1, 1'b0);
		clr_low <= 1'b1;
		apb(1'b1, pmca_pkg::PT_BASE + 12'h010, 32'h0000_0200);
		apb(1'b1, pmca_pkg::MC_CFG_BASE, 32'h0040_0010);
		drive[5] <= 1'b1;
		pin_chk(0, 1'b1, 1'b1);
		// Pin 2 follows the second enable pin
		apb(1'b1, pmca_pkg::IO_CFG_BASE + 12'h008, 32'h0000_0003);
		apb(1'b1, pmca_pkg::GLOBAL_CFG_OFF, 32'h0000_003C);
		oe_b_low <= 1'b0;
		pin_chk(2, 1'b1, 1'b0);
		oe_b_low <= 1'b1;
		pin_chk(2, 1'b0, 1'b0);
		// Cell 4 borrows from 3, cell 8 may not borrow from 7, cell 6 uses expander 3
		apb(1'b1, pmca_pkg::PT_BASE + 12'h0F0, 32'h0000_0200);
		apb(1'b1, pmca_pkg::PT_BASE + 12'h230, 32'h0000_0200);
		apb(1'b1, pmca_pkg::PT_BASE + 12'h1E4, 32'h0000_0080);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h00C, 32'h0000_0005);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h01C, 32'h0000_0005);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h010, 32'h0104_0000);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h020, 32'h0104_0000);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h018, 32'h0004_0000);
		for (int p = 4; p <= 8; p += 2) begin
			apb(1'b1, pmca_pkg::IO_CFG_BASE + 12'(4 * p), 32'h0000_0001);
		end
		pin_chk(4, 1'b1, 1'b1);
		pin_chk(8, 1'b1, 1'b0);
		pin_chk(6, 1'b1, 1'b0);
		drive[5] <= 1'b0;
		pin_chk(4, 1'b1, 1'b0);
		pin_chk(6, 1'b1, 1'b1);
		// Enhanced: pin b clocks cell 10, fast pin inputs on cells 9 and 10
		apb(1'b1, pmca_pkg::GLOBAL_CFG_OFF, 32'h0000_047D);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h024, 32'h0080_0000);
		apb(1'b1, pmca_pkg::MC_CFG_BASE + 12'h028, 32'h00A0_0000);
		drive[10:9] <= 2'h3;
		oe_b_low    <= 1'b0;
		repeat (4) @(posedge clk);
		oe_b_low <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, pmca_pkg::MC_STATE_OFF, 32'h0000_0000);
		chk({30'h0, q[10:9]}, 32'h0000_0002);
		clk_a <= 1'b1;
		repeat (4) @(posedge clk);
		clk_a <= 1'b0;
		apb(1'b0, pmca_pkg::MC_STATE_OFF, 32'h0000_0000);
		chk({30'h0, q[10:9]}, 32'h0000_0003);
		// Enable 0 taken from pin 5, then open drain on pin 1
		apb(1'b1, pmca_pkg::OE_CFG_BASE, 32'h0000_0029);
		pin_chk(1, 1'b0, 1'b1);
		drive[5] <= 1'b1;
		pin_chk(1, 1'b1, 1'b1);
		apb(1'b1, pmca_pkg::IO_CFG_BASE + 12'h004, 32'h0000_000A);
		pin_chk(1, 1'b1, 1'b1);
		apb(1'b1, pmca_pkg::GLOBAL_CFG_OFF, 32'h0000_047F);
		pin_chk(1, 1'b0, 1'b0);
		// Second reset in mid-run
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(pmca_pkg::GLOBAL_CFG_OFF, pmca_pkg::CFG_RESET, 1'b0);
		rd(pmca_pkg::MC_STATE_OFF, 32'h0000_0000, 1'b0);
		chk({16'h0000, pin_oe}, 32'h0000_0000);
		finish_test();
	end

	// A hang counts against the run
	initial begin
		#100000;
		failures++;
		finish_test();
	end
endmodule : tb_top
